/* rtl/dds_word_device.sv */
// oscillator end: serial word decoder, registers, accumulator and output
// assumes the host frames words correctly on the link modport
// How it works
// - two 28-bit frequency words, one selected
// - two 12-bit phase offsets, one added
// - top bits 01/10 write frequency word data
// - top 110/111 load phase, low twelve bits
// - top bits 00 write the control word
// - full mode: first write low, second high
// - half mode: one write changes one half
// - half choice zero updates low half only
// - half choice bit 12, full load bit 13
// - reset bit holds accumulator at zero
// - clock halt freezes output code, and accumulator unless reset bit also set
// - ramp mode sends phase straight to converter
// - half choice one updates high half
// - sine mode converts phase through parabolic approximation
// - frame low, one bit per falling edge
// - msb output routes accumulator top bit, halved unless bypass set
module dds_word_device
  import dds_link_pkg::*;
(
  input  wire logic                            CLOCK,
  input  wire logic                            RESETN,
  dds_link_if.dev                              LINK,
  output logic [dds_link_pkg::CODE_BITS-1:0]   ANALOG_OUT,
  output logic                                 CONVERTER_OFF
);
  import dds_link_pkg::*;

  // link side state, clocked by falling serial clock
  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
    logic [WORD_BITS-1:0] word;
    logic                 toggle;
  } link_t;

  // core side state, clocked by the master clock
  typedef struct packed {
    logic [FREQ_BITS-1:0]  freq0;
    logic [FREQ_BITS-1:0]  freq1;
    logic [PHASE_BITS-1:0] phase0;
    logic [PHASE_BITS-1:0] phase1;
    logic [HALF_BITS-1:0]  ctrl;
    logic                  pend;
    logic                  pend_sel;
    logic [HALF_BITS-1:0]  lo_hold;
    logic                  seen;
    logic [FREQ_BITS-1:0]  acc;
    logic [CODE_BITS-1:0]  code;
    logic                  square;
    logic                  msb_prev;
  } core_t;

  link_t                 l_q;
  link_t                 l_d;
  core_t                 c_q;
  core_t                 c_d;
  logic [4:0]            bit_cnt_q;
  logic                  tog_sync;
  logic [WORD_BITS-1:0]  rx;
  logic [PHASE_BITS-1:0] phase;

  // bit counter cleared while the frame is idle
  always_ff @(negedge LINK.sclk or posedge LINK.frame_sync_n or negedge RESETN) begin
    if (!RESETN) begin
      bit_cnt_q <= 5'h00;
    end else if (LINK.frame_sync_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != 5'h10) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_comb begin
    l_d = l_q;
    if (!LINK.frame_sync_n && bit_cnt_q != 5'h10) begin
      l_d.shift = {l_q.shift[WORD_BITS-2:0], LINK.serial_data_in};
      if (bit_cnt_q == 5'h0f) begin
        l_d.word   = {l_q.shift[WORD_BITS-2:0], LINK.serial_data_in};
        l_d.toggle = ~l_q.toggle;
      end
    end
  end

  always_ff @(negedge LINK.sclk or negedge RESETN) begin
    if (!RESETN) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // completed word announced by toggle; word stays still while it crosses
  level_sync #(
    .W (1)
  ) u_word_sync (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .d     (l_q.toggle),
    .q     (tog_sync)
  );

  // parabolic approximation of one sine period
  function automatic logic [CODE_BITS-1:0] sine_of(input logic [PHASE_BITS-1:0] p);
    logic [10:0] half;
    logic [21:0] prod;
    logic [9:0]  amp;
    half = p[10:0];
    prod = {11'h000, half} * (22'h000800 - {11'h000, half});
    amp  = (prod[21:11] > 11'h1ff) ? 10'h1ff : prod[20:11];
    if (p[11]) begin
      sine_of = MIDSCALE - amp;
    end else begin
      sine_of = MIDSCALE + amp;
    end
  endfunction : sine_of

  assign rx    = l_q.word;
  assign phase = c_q.acc[FREQ_BITS-1 -: PHASE_BITS]
               + (c_q.ctrl[PHASE_CHOICE_POS] ? c_q.phase1 : c_q.phase0);

  always_comb begin
    logic                 sel;
    logic [HALF_BITS-1:0] data;
    logic [FREQ_BITS-1:0] word;
    c_d  = c_q;
    sel  = (rx[15:14] == CMD_FREQ1);
    data = rx[HALF_BITS-1:0];
    word = sel ? c_q.freq1 : c_q.freq0;
    c_d.seen = tog_sync;
    if (tog_sync != c_q.seen) begin
      if (rx[15:14] == CMD_FREQ0 || rx[15:14] == CMD_FREQ1) begin
        if (c_q.ctrl[FULL_WORD_POS]) begin
          if (c_q.pend && c_q.pend_sel == sel) begin
            word     = {data, c_q.lo_hold};
            c_d.pend = 1'b0;
          end else begin
            c_d.lo_hold  = data;
            c_d.pend     = 1'b1;
            c_d.pend_sel = sel;
          end
        end else if (c_q.ctrl[HALF_CHOICE_POS]) begin
          word[FREQ_BITS-1:HALF_BITS] = data;
        end else begin
          word[HALF_BITS-1:0] = data;
        end
        if (sel) begin
          c_d.freq1 = word;
        end else begin
          c_d.freq0 = word;
        end
      end else if (rx[15:14] == CMD_CTRL) begin
        c_d.ctrl = rx[HALF_BITS-1:0];
        c_d.pend = 1'b0;
      end else begin
        if (rx[PHASE_SEL_POS]) begin
          c_d.phase1 = rx[PHASE_BITS-1:0];
        end else begin
          c_d.phase0 = rx[PHASE_BITS-1:0];
        end
        c_d.pend = 1'b0;
      end
    end
    // accumulator and output path
    if (c_q.ctrl[ACC_RESET_POS]) begin
      c_d.acc = '0;
    end else if (!c_q.ctrl[CLOCK_HALT_POS]) begin
      c_d.acc = c_q.acc + (c_q.ctrl[FREQ_CHOICE_POS] ? c_q.freq1 : c_q.freq0);
    end
    if (!c_q.ctrl[CLOCK_HALT_POS]) begin
      c_d.msb_prev = c_q.acc[FREQ_BITS-1];
      if (c_q.acc[FREQ_BITS-1] && !c_q.msb_prev) begin
        c_d.square = ~c_q.square;
      end
      if (c_q.ctrl[MSB_OUT_POS]) begin
        if (c_q.ctrl[SQ_BYPASS_POS]) begin
          c_d.code = c_q.acc[FREQ_BITS-1] ? 10'h3ff : 10'h000;
        end else begin
          c_d.code = c_q.square ? 10'h3ff : 10'h000;
        end
      end else if (c_q.ctrl[POWERDOWN_POS]) begin
        c_d.code = 10'h000;
      end else if (c_q.ctrl[RAMP_MODE_POS]) begin
        c_d.code = phase[PHASE_BITS-1 -: CODE_BITS];
      end else begin
        c_d.code = sine_of(phase);
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      c_q        <= '0;
      c_q.freq0  <= FREQ_RESET;
      c_q.freq1  <= FREQ_RESET;
      c_q.phase0 <= PHASE_RESET;
      c_q.phase1 <= PHASE_RESET;
      c_q.ctrl   <= CTRL_RESET;
      c_q.code   <= MIDSCALE;
    end else begin
      c_q <= c_d;
    end
  end

  assign ANALOG_OUT    = c_q.code;
  assign CONVERTER_OFF = c_q.ctrl[POWERDOWN_POS] & ~c_q.ctrl[MSB_OUT_POS];
endmodule : dds_word_device

/* common/dds_link_pkg.sv */
// constants shared by both ends of the serial oscillator link
// assumes a 40 MHz system clock on the host and a link clock divided down from it
package dds_link_pkg;
  localparam int          WORD_BITS        = 16;
  localparam int          FREQ_BITS        = 28;
  localparam int          HALF_BITS        = 14;
  localparam int          PHASE_BITS       = 12;
  localparam int          CODE_BITS        = 10;
  // command field in the top bits of a serial word
  localparam logic [1:0]  CMD_CTRL         = 2'h0;
  localparam logic [1:0]  CMD_FREQ0        = 2'h1;
  localparam logic [1:0]  CMD_FREQ1        = 2'h2;
  localparam logic [1:0]  CMD_PHASE        = 2'h3;
  localparam int          PHASE_SEL_POS    = 13;
  // control word fields
  localparam int          FULL_WORD_POS    = 13;
  localparam int          HALF_CHOICE_POS  = 12;
  localparam int          FREQ_CHOICE_POS  = 11;
  localparam int          PHASE_CHOICE_POS = 10;
  localparam int          ACC_RESET_POS    = 8;
  localparam int          CLOCK_HALT_POS   = 7;
  localparam int          POWERDOWN_POS    = 6;
  localparam int          MSB_OUT_POS      = 5;
  localparam int          SQ_BYPASS_POS    = 3;
  localparam int          RAMP_MODE_POS    = 1;
  localparam logic [13:0] CTRL_RESET       = 14'h0000;
  localparam logic [27:0] FREQ_RESET       = 28'h0000000;
  localparam logic [11:0] PHASE_RESET      = 12'h000;
  localparam logic [9:0]  MIDSCALE         = 10'h200;
  // host register map
  localparam logic [7:0]  OFS_COMMAND      = 8'h00;
  localparam logic [7:0]  OFS_STATUS       = 8'h04;
  localparam logic [7:0]  OFS_LAST_WORD    = 8'h08;
  localparam int          STAT_BUSY_POS    = 0;
  localparam int          STAT_DROP_POS    = 1;
  // link timing
  localparam int          CLOCK_PERIOD_NS  = 25;
  localparam int          SCLK_HALF_NS     = 50;
  localparam int          SCLK_HALF_CYCLES =
    (SCLK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
endpackage : dds_link_pkg

/* common/dds_link_if.sv */
// three-wire serial write link between host and oscillator
// assumes the host drives all wires; the device only listens
interface dds_link_if;
  logic sclk;
  logic serial_data_in;
  logic frame_sync_n;
  modport host (output sclk, output serial_data_in, output frame_sync_n);
  modport dev  (input sclk, input serial_data_in, input frame_sync_n);
endinterface : dds_link_if

/* rtl/level_sync.sv */
// two-flop synchroniser for a bundle of levels
// assumes each bit changes at most once per several destination cycles
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_t;
  sync_t s_q;
  sync_t s_d;
  always_comb begin
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign q = s_q.sync;
endmodule : level_sync

/* rtl/dds_word_host.sv */
// host end: APB command registers driving the three-wire serial link
// assumes an APB master on the system clock; link clock made here by a divider
module dds_word_host
  import dds_link_pkg::*;
#(
  parameter int HALF_CYCLES = dds_link_pkg::SCLK_HALF_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  dds_link_if.host         LINK
);
  import dds_link_pkg::*;

  typedef enum logic [3:0] {
    IDLE = 4'b0001,
    LEAD = 4'b0010,
    SEND = 4'b0100,
    TAIL = 4'b1000
  } state_t;

  typedef struct packed {
    state_t               state;
    logic [15:0]          div;
    logic [4:0]           falls;
    logic [WORD_BITS-1:0] shift;
    logic [WORD_BITS-1:0] last;
    logic                 drop;
    logic                 sclk;
    logic                 sdo;
    logic                 frame_sync_n_n;
  } host_t;

  host_t h_q;
  host_t h_d;
  logic  wr;
  logic  tick;
  logic  mapped;

  assign wr     = PSEL & PENABLE & PWRITE;
  assign tick   = (h_q.div == 16'(HALF_CYCLES - 1));
  assign mapped = (PADDR == OFS_COMMAND) | (PADDR == OFS_STATUS) | (PADDR == OFS_LAST_WORD);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  always_comb begin
    PRDATA = 32'h00000000;
    if (PADDR == OFS_STATUS) begin
      PRDATA[STAT_BUSY_POS] = (h_q.state != IDLE);
      PRDATA[STAT_DROP_POS] = h_q.drop;
    end else if (PADDR == OFS_LAST_WORD) begin
      PRDATA[WORD_BITS-1:0] = h_q.last;
    end
  end

  always_comb begin
    h_d     = h_q;
    h_d.div = tick ? 16'h0000 : h_q.div + 16'h0001;
    if (wr && PADDR == OFS_STATUS && PWDATA[STAT_DROP_POS]) begin
      h_d.drop = 1'b0;
    end
    case (h_q.state)
      IDLE: begin
        if (wr && PADDR == OFS_COMMAND) begin
          h_d.state   = LEAD;
          h_d.div     = 16'h0000;
          h_d.shift   = PWDATA[WORD_BITS-1:0];
          h_d.last    = PWDATA[WORD_BITS-1:0];
          h_d.sdo     = PWDATA[WORD_BITS-1];
          h_d.frame_sync_n_n = 1'b0;
          h_d.falls   = 5'h00;
        end
      end
      LEAD: begin
        if (tick) begin
          h_d.state = SEND;
          h_d.sclk  = 1'b0;
          h_d.falls = 5'h01;
        end
      end
      SEND: begin
        if (tick) begin
          if (h_q.sclk) begin
            h_d.sclk  = 1'b0;
            h_d.falls = h_q.falls + 5'h01;
          end else if (h_q.falls == 5'h10) begin
            h_d.sclk  = 1'b1;
            h_d.state = TAIL;
          end else begin
            h_d.sclk  = 1'b1;
            h_d.shift = {h_q.shift[WORD_BITS-2:0], 1'b0};
            h_d.sdo   = h_q.shift[WORD_BITS-2];
          end
        end
      end
      TAIL: begin
        if (tick) begin
          h_d.frame_sync_n_n = 1'b1;
          h_d.sdo     = 1'b0;
          h_d.state   = IDLE;
        end
      end
      default: begin
        h_d.state = IDLE;
      end
    endcase
    if (wr && PADDR == OFS_COMMAND && h_q.state != IDLE) begin
      h_d.drop = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      h_q         <= '0;
      h_q.state   <= IDLE;
      h_q.sclk    <= 1'b1;
      h_q.frame_sync_n_n <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign LINK.sclk           = h_q.sclk;
  assign LINK.serial_data_in = h_q.sdo;
  assign LINK.frame_sync_n   = h_q.frame_sync_n_n;
endmodule : dds_word_host

/* tb/dds_link_properties.sv */
// checks on the three wires between host and oscillator ends
// assumes sampling on the host clock, link made by its divider
module dds_link_properties #(
  parameter int HALF_CYCLES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic frame_sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME_CYCLES = 33 * HALF_CYCLES;
  logic       sclk_prev_q;
  logic [7:0] run_q;
  logic [4:0] falls_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // run length of the link clock level, falls per frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b1;
      run_q       <= 8'h00;
      falls_q     <= 5'h00;
    end else begin
      sclk_prev_q <= sclk;
      run_q       <= (sclk != sclk_prev_q) ? 8'h01 : run_q + {7'h00, run_q != 8'hff};
      falls_q     <= frame_sync_n ? 5'h00 : falls_q + {4'h0, !sclk && sclk_prev_q};
    end
  end
  a_idle_clock_high: assert property (frame_sync_n |-> sclk)
    else $error("link clock low outside a frame");
  a_first_fall_setup: assert property ($fell(frame_sync_n) |-> sclk ##HALF_CYCLES $fell(sclk))
    else $error("first fall not one half period after frame start");
  a_low_half_width: assert property ($rose(sclk) && !frame_sync_n |-> run_q == HALF_CYCLES)
    else $error("link clock low phase wrong length");
  a_high_half_width: assert property ($fell(sclk) && falls_q != 5'h00 |-> run_q == HALF_CYCLES)
    else $error("link clock high phase wrong length");
  a_sixteen_falls: assert property ($rose(frame_sync_n) |-> falls_q == 5'h10 && sclk)
    else $error("frame closed without sixteen falls");
  a_falls_bounded: assert property (falls_q <= 5'h10)
    else $error("more than sixteen falls in a frame");
  a_frame_length: assert property ($fell(frame_sync_n) |-> ##FRAME_CYCLES $rose(frame_sync_n))
    else $error("frame length wrong");
  a_data_hold_fall: assert property ($fell(sclk) |-> $stable(serial_data_in))
    else $error("data moved at a sampling fall");
  a_data_moves_rise: assert property (
    !frame_sync_n && !$past(frame_sync_n) && $changed(serial_data_in) |-> $rose(sclk))
    else $error("data moved away from a rising edge");
  c_frame_done: cover property ($rose(frame_sync_n));
  c_first_fall: cover property ($fell(frame_sync_n) ##HALF_CYCLES $fell(sclk));
  c_data_one: cover property ($fell(sclk) && serial_data_in);
endmodule : dds_link_properties

/* tb/dds_serial_word_decoder_tb.sv */
// bench joining host and oscillator ends, driven over apb
// assumes the package map; device master clock made here
module dds_serial_word_decoder_tb
  import dds_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] RST  = 14'h1 << ACC_RESET_POS;
  localparam logic [13:0] RAMP = 14'h1 << RAMP_MODE_POS;
  localparam logic [13:0] PSC  = 14'h1 << PHASE_CHOICE_POS;
  localparam logic [13:0] FSC  = 14'h1 << FREQ_CHOICE_POS;
  localparam logic [13:0] HALF = 14'h1 << HALF_CHOICE_POS;
  localparam logic [13:0] FULL = 14'h1 << FULL_WORD_POS;
  localparam logic [13:0] HALT = 14'h1 << CLOCK_HALT_POS;
  localparam logic [13:0] PD   = 14'h1 << POWERDOWN_POS;
  localparam logic [13:0] MSB  = 14'h1 << MSB_OUT_POS;
  localparam logic [13:0] BYP  = 14'h1 << SQ_BYPASS_POS;
  logic        clk     = 1'b0;
  logic        mclk    = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, conv_off, sel;
  logic [9:0]  analog_out, base;
  logic [11:0] off;
  int          seed      = 71617;
  int          failures  = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  always #12.5 clk = ~clk;
  always #16 mclk = ~mclk;
  dds_link_if link ();
  dds_word_host #(.HALF_CYCLES(2)) i_dds_word_host (.CLOCK(clk), .RESETN(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  dds_word_device i_dds_word_device (.CLOCK(mclk), .RESETN(rst_n), .LINK(link),
    .ANALOG_OUT(analog_out), .CONVERTER_OFF(conv_off));
  dds_link_properties #(.HALF_CYCLES(2)) i_dds_link_properties (.clk(clk), .rst_n(rst_n),
    .sclk(link.sclk), .serial_data_in(link.serial_data_in), .frame_sync_n(link.frame_sync_n));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic check_code(input logic [9:0] got, input logic [9:0] exp, input string what);
    check({22'h0, got}, {22'h0, exp}, what);
  endtask : check_code
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    rd = 32'h1;
    while (rd[STAT_BUSY_POS] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
    repeat (6) @(posedge mclk);
  endtask : wait_idle
  task automatic send(input logic [15:0] w);
    apb(1'b1, OFS_COMMAND, {16'h0, w});
    wait_idle();
  endtask : send
  task automatic code_is(input logic [9:0] exp);
    @(negedge mclk);
    check_code(analog_out, exp, "output code");
  endtask : code_is
  // ramp code advance over n cycles; exact when n*freq is a multiple of 2^18
  function automatic logic [9:0] ramp_gain(input logic [27:0] freq, input int n);
    logic [59:0] total;
    total     = 60'(freq) * 60'(n);
    ramp_gain = total[27:18];
  endfunction : ramp_gain
  task automatic step_is(input logic [9:0] exp, input int n);
    @(negedge mclk);
    base = analog_out;
    repeat (n) @(negedge mclk);
    check_code(analog_out - base, exp, "ramp step");
  endtask : step_is
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    code_is(MIDSCALE);
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      off = 12'($random(seed));
      sel = 1'(i);
      send({2'b11, sel, 1'b0, off});
      send({2'b00, RST | RAMP | (sel ? PSC : 14'h0)});
      code_is(off[11:2]);
    end
    apb(1'b0, OFS_LAST_WORD, 32'h0);
    check(rd, {18'h0, RST | RAMP | PSC}, "last word");
    $display("test phase offsets done");
    send(16'hc000);
    send({2'b00, RST});
    code_is(MIDSCALE);
    send({2'b00, RST | PD});
    check({31'h0, conv_off}, 32'h1, "converter off");
    send({2'b00, RST | PD | MSB | BYP});
    code_is(10'h000);
    check({31'h0, conv_off}, 32'h0, "converter on");
    $display("test output modes done");
    send({2'b00, FULL | RST | RAMP});
    send(16'h4000);
    send(16'h4010);
    send({2'b00, FULL | RAMP});
    step_is(ramp_gain({14'h0010, 14'h0000}, 1), 1);
    send({2'b00, FULL | RAMP | HALT});
    step_is(10'h000, 4);
    $display("test full load and halt done");
    send({2'b00, RST | HALF | RAMP | FSC});
    send(16'h8020);
    send({2'b00, RST | RAMP | FSC});
    send(16'ha000);
    send({2'b00, RAMP | FSC});
    step_is(ramp_gain({14'h0020, 14'h2000}, 32), 32);
    send({2'b00, RAMP});
    step_is(ramp_gain({14'h0010, 14'h0000}, 1), 1);
    $display("test half load done");
    apb(1'b1, OFS_COMMAND, {18'h0, RAMP});
    apb(1'b1, OFS_COMMAND, {18'h0, RAMP});
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h3, "busy and dropped");
    wait_idle();
    apb(1'b1, OFS_STATUS, 32'h2);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0, "drop cleared");
    $display("test refused command done");
    wrap_up();
  end
endmodule : dds_serial_word_decoder_tb
